//--- dac_pkg.sv
// Shared constants for the converter register control block.
// Assumes an 8-bit register port and a single bus clock.
package dac_pkg;
	localparam int                 DATA_W           = 8;
	localparam int                 ADDR_W           = 2;
	localparam logic [ADDR_W-1:0]  CONTROL_OFFSET   = 2'h0;
	localparam logic [ADDR_W-1:0]  RESERVED_OFFSET  = 2'h1;
	localparam logic [ADDR_W-1:0]  LEFT_OFFSET      = 2'h2;
	localparam logic [ADDR_W-1:0]  RIGHT_OFFSET     = 2'h3;
	localparam int                 ENABLE_BIT       = 7;
	localparam int                 TEST_BIT         = 6;
	localparam int                 JUSTIFY_BIT      = 3;
	localparam int                 SIGN_BIT         = 2;
	localparam int                 WAIT_STOP_BIT    = 1;
	localparam int                 PIN_ENABLE_BIT   = 0;
	localparam logic [DATA_W-1:0]  CONTROL_RESET    = 8'h00;
	localparam logic [DATA_W-1:0]  CONTROL_WR_MASK  = 8'hCF;
	localparam logic [DATA_W-1:0]  DATA_RESET       = 8'h00;
	localparam logic [DATA_W-1:0]  ZERO_BYTE        = 8'h00;
	typedef enum logic [1:0] {
		CONV_OFF,
		CONV_RUN,
		CONV_HALT
	} conv_state_type;
endpackage

//--- dac_code_format.sv
// Turns the stored data byte into the unsigned code for the analog core.
// Assumes the sign selection is stable from the control register.
`timescale 1ns/10ps
module dac_code_format #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] data_in,
	input  wire logic         signed_mode,
	output logic      [W-1:0] code_out
);
	// Flipping the top bit maps 80 to 00 and 7F to FF.
	assign code_out = signed_mode ? {~data_in[W-1], data_in[W-2:0]} : data_in; // [RULE16] [RULE13] [RULE11]
endmodule

//--- dac_power_ctrl.sv
// Power sequencing of the converter across run, wait and stop modes.
// Assumes wait and stop requests come synchronous to the bus clock.
`timescale 1ns/10ps
module dac_power_ctrl (
	input  wire logic                    clk,
	input  wire logic                    sys_rst,
	input  wire logic                    enable,
	input  wire logic                    wait_stop,
	input  wire logic                    wait_mode,
	input  wire logic                    stop_mode,
	output dac_pkg::conv_state_type      state
);
	dac_pkg::conv_state_type nxt_state;

	always_comb begin
		unique case (state)
			dac_pkg::CONV_OFF: begin
				nxt_state = enable ? dac_pkg::CONV_RUN : dac_pkg::CONV_OFF; // [RULE14]
			end
			dac_pkg::CONV_RUN, dac_pkg::CONV_HALT: begin
				if (!enable) begin
					nxt_state = dac_pkg::CONV_OFF; // [RULE5]
				end else if (stop_mode || (wait_mode && wait_stop)) begin
					nxt_state = dac_pkg::CONV_HALT; // [RULE2] [RULE3]
				end else begin
					nxt_state = dac_pkg::CONV_RUN;
				end
			end
			default: begin
				nxt_state = dac_pkg::CONV_OFF;
			end
		endcase
		if (enable && state == dac_pkg::CONV_OFF && (stop_mode || (wait_mode && wait_stop))) begin
			nxt_state = dac_pkg::CONV_HALT;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= dac_pkg::CONV_OFF; // [RULE15]
		end else begin
			state <= nxt_state;
		end
	end
endmodule

//--- dac_register_control.sv
// What this block does
// [RULE1] Takes 8-bit data, drives one output.
// [RULE2] Wait-stop bit set halts converter in wait.
// [RULE3] Stop mode disables converter, registers kept.
// [RULE4] Control register always accessible; bits 5,4 zero.
// [RULE5] Enable bit powers converter and output.
// [RULE6] Pin driven only with enable and output-enable.
// [RULE7] Test bit writable only in special modes.
// [RULE8] Left register active when justify bit clear.
// [RULE9] Right register active when justify bit set.
// [RULE10] Stored value survives justification change.
// [RULE11] Sign bit selects unsigned or signed data.
// [RULE12] Reserved register reads zero, ignores writes.
// [RULE13] Signed 7F full scale, 80 zero scale.
// [RULE14] Conversion starts once enable bit set.
// [RULE15] Reset clears registers and powers down.
// [RULE16] Core sees unsigned code, signed MSB inverted.
//
// Top of the converter control: register port, data path and pin controls.
// Assumes a single-cycle read/write strobe master on the bus clock.
`timescale 1ns/10ps
module dac_register_control #(
	parameter int DATA_W = dac_pkg::DATA_W,
	parameter int ADDR_W = dac_pkg::ADDR_W
) (
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              wr_en,
	input  wire logic              rd_en,
	input  wire logic              special_mode,
	input  wire logic              wait_mode,
	input  wire logic              stop_mode,
	output logic      [DATA_W-1:0] rdata,
	output logic      [DATA_W-1:0] conversion_data,
	output logic                   converter_power,
	output logic                   converting,
	output logic                   analog_output_pin_oe,
	output logic                   factory_test_enable
);
	logic [DATA_W-1:0]       converter_control_ff;
	logic [DATA_W-1:0]       data_ff;
	logic [DATA_W-1:0]       rdata_ff;
	logic [DATA_W-1:0]       code_ff;
	logic [DATA_W-1:0]       code_w;
	logic [DATA_W-1:0]       nxt_rdata;
	logic                    power_ff;
	logic                    conv_ff;
	logic                    oe_ff;
	logic                    test_ff;
	logic                    converter_enable;
	logic                    justify_select;
	logic                    sign_select;
	logic                    wait_stop;
	logic                    output_pin_enable;
	dac_pkg::conv_state_type state;
	logic [DATA_W-1:0]       nxt_control;
	logic                    control_write;
	logic                    data_write;
	logic                    run_allowed;
	logic                    drive_allowed;

	// Decodes one register offset against the bus address.
	function automatic logic offset_hit(
		input logic [ADDR_W-1:0] bus_addr,
		input logic [ADDR_W-1:0] offset
	);
		return bus_addr == offset;
	endfunction

	// True when the offset is the data window that the justify bit opens.
	function automatic logic window_open(
		input logic [ADDR_W-1:0] bus_addr,
		input logic              justify
	);
		logic open;
		if (justify) begin
			open = offset_hit(bus_addr, dac_pkg::RIGHT_OFFSET); // [RULE9]
		end else begin
			open = offset_hit(bus_addr, dac_pkg::LEFT_OFFSET); // [RULE8]
		end
		return open;
	endfunction

	// True while no low-power mode holds the converter down.
	function automatic logic awake(
		input logic wait_stop_bit,
		input logic in_wait,
		input logic in_stop
	);
		return !in_stop && !(in_wait && wait_stop_bit); // [RULE2] [RULE3]
	endfunction

	// Whether a control bit takes the written value in the present mode.
	function automatic logic bit_writable(
		input int   index,
		input logic special
	);
		logic ok;
		ok = dac_pkg::CONTROL_WR_MASK[index];
		if (index == dac_pkg::TEST_BIT) begin
			ok = ok && special; // [RULE7]
		end
		return ok;
	endfunction

	assign converter_enable  = converter_control_ff[dac_pkg::ENABLE_BIT];
	assign justify_select    = converter_control_ff[dac_pkg::JUSTIFY_BIT];
	assign sign_select       = converter_control_ff[dac_pkg::SIGN_BIT];
	assign wait_stop         = converter_control_ff[dac_pkg::WAIT_STOP_BIT];
	assign output_pin_enable = converter_control_ff[dac_pkg::PIN_ENABLE_BIT];

	// Writable bits take the bus, the test bit holds outside special modes.
	for (genvar b = 0; b < DATA_W; b++) begin : g_control_bit
		logic take;
		logic keep;
		assign take           = bit_writable(b, special_mode); // [RULE7]
		assign keep           = dac_pkg::CONTROL_WR_MASK[b] && !take;
		assign nxt_control[b] = take ? wdata[b] : (keep && converter_control_ff[b]); // [RULE4]
	end

	assign control_write = wr_en && offset_hit(addr, dac_pkg::CONTROL_OFFSET);

	// Control register; every field updates from one merged byte.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			converter_control_ff <= dac_pkg::CONTROL_RESET; // [RULE15]
		end else if (control_write) begin
			converter_control_ff <= nxt_control; // [RULE4] [RULE7]
		end
	end

	assign data_write = wr_en && window_open(addr, justify_select); // [RULE8] [RULE9]

	// One shared data byte reached through whichever window is selected.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			data_ff <= dac_pkg::DATA_RESET; // [RULE15]
		end else if (data_write) begin
			data_ff <= wdata; // [RULE1] [RULE10]
		end
	end

	always_comb begin
		unique case (addr)
			dac_pkg::CONTROL_OFFSET: begin
				nxt_rdata = converter_control_ff; // [RULE4]
			end
			dac_pkg::RESERVED_OFFSET: begin
				nxt_rdata = dac_pkg::ZERO_BYTE; // [RULE12]
			end
			dac_pkg::LEFT_OFFSET, dac_pkg::RIGHT_OFFSET: begin
				if (window_open(addr, justify_select)) begin
					nxt_rdata = data_ff; // [RULE8] [RULE9] [RULE10]
				end else begin
					nxt_rdata = dac_pkg::ZERO_BYTE; // [RULE8] [RULE9]
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_ff <= dac_pkg::ZERO_BYTE;
		end else if (rd_en) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= dac_pkg::ZERO_BYTE;
		end
	end

	dac_code_format #(
		.W(DATA_W)
	) u_format (
		.data_in    (data_ff),
		.signed_mode(sign_select),
		.code_out   (code_w)
	);

	dac_power_ctrl u_power (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.enable   (converter_enable),
		.wait_stop(wait_stop),
		.wait_mode(wait_mode),
		.stop_mode(stop_mode),
		.state    (state)
	);

	assign run_allowed   = converter_enable && awake(wait_stop, wait_mode, stop_mode); // [RULE14]
	assign drive_allowed = run_allowed && output_pin_enable; // [RULE6]

	// Code presented to the analog core.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			code_ff <= dac_pkg::ZERO_BYTE; // [RULE15]
		end else begin
			code_ff <= code_w; // [RULE1] [RULE16]
		end
	end

	// Converter supply, dropped while disabled or held by a low-power mode.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			power_ff <= 1'b0; // [RULE15]
		end else begin
			power_ff <= run_allowed; // [RULE5] [RULE2] [RULE3]
		end
	end

	// Conversion activity follows the supply.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			conv_ff <= 1'b0; // [RULE15]
		end else begin
			conv_ff <= run_allowed; // [RULE14]
		end
	end

	// Pin drive needs both enables and an awake converter.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			oe_ff <= 1'b0; // [RULE15]
		end else begin
			oe_ff <= drive_allowed; // [RULE6]
		end
	end

	// Registered copy of the test bit for the analog core.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			test_ff <= 1'b0; // [RULE15]
		end else begin
			test_ff <= converter_control_ff[dac_pkg::TEST_BIT]; // [RULE7]
		end
	end

	assign rdata                = rdata_ff;
	assign conversion_data      = code_ff;
	assign converter_power      = power_ff;
	assign converting           = conv_ff;
	assign analog_output_pin_oe = oe_ff;
	assign factory_test_enable  = test_ff;
endmodule

//--- dac_register_control_monitor.sv
// Port checker for the converter register control block.
// Assumes one bus clock and a synchronous active high reset.
`timescale 1ns/10ps
module dac_register_monitor (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic       special_mode,
	input wire logic       wait_mode,
	input wire logic       stop_mode,
	input wire logic [7:0] rdata,
	input wire logic       converter_power,
	input wire logic       converting,
	input wire logic       analog_output_pin_oe,
	input wire logic       factory_test_enable
);
	logic [7:0] ctl_ff;
	logic       run;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Shadow of the control bits that steer power and data selection.
	always_ff @(posedge clk) begin
		if (sys_rst)
			ctl_ff <= 8'h00;
		else if (wr_en && addr == 2'h0)
			ctl_ff <= wdata;
	end
	assign run = ctl_ff[7] && !stop_mode && !(wait_mode && ctl_ff[1]);
	property p_pwr; converter_power == $past(run && !sys_rst); endproperty
	a_pwr: assert property (p_pwr) else $error("power level wrong");
	property p_oe; analog_output_pin_oe == $past(run && ctl_ff[0] && !sys_rst); endproperty
	a_oe: assert property (p_oe) else $error("pin drive wrong");
	property p_conv; converting == converter_power; endproperty
	a_conv: assert property (p_conv) else $error("converting wrong");
	property p_wait; wait_mode && ctl_ff[1] |=> !converter_power; endproperty
	a_wait: assert property (p_wait) else $error("wait not halting");
	property p_stop; stop_mode |=> !converter_power && !analog_output_pin_oe; endproperty
	a_stop: assert property (p_stop) else $error("stop not halting");
	property p_rsv; rd_en && addr == 2'h1 |=> rdata == 8'h00; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved not zero");
	property p_just; rd_en && addr[1] && addr[0] != ctl_ff[3] |=> rdata == 8'h00; endproperty
	a_just: assert property (p_just) else $error("idle data not zero");
	property p_ctl; rd_en && addr == 2'h0 |=> rdata[5:4] == 2'b00; endproperty
	a_ctl: assert property (p_ctl) else $error("control bits wrong");
	property p_tst; $rose(factory_test_enable) |-> $past(special_mode, 2) || $past(special_mode); endproperty
	a_tst: assert property (p_tst) else $error("test bit set");
endmodule
bind dac_register_control dac_register_monitor chk (
	.clk                 (clk),
	.sys_rst             (sys_rst),
	.addr                (addr),
	.wdata               (wdata),
	.wr_en               (wr_en),
	.rd_en               (rd_en),
	.special_mode        (special_mode),
	.wait_mode           (wait_mode),
	.stop_mode           (stop_mode),
	.rdata               (rdata),
	.converter_power     (converter_power),
	.converting          (converting),
	.analog_output_pin_oe(analog_output_pin_oe),
	.factory_test_enable (factory_test_enable)
);

//--- test_dac_register_control.sv
// Self-checking bench for the converter register control block.
// Assumes the block and its checker are compiled before this file.
`timescale 1ns/10ps
module test_dac_register_control;
	logic        clk, sys_rst, wr_en, rd_en, special_mode, wait_mode, stop_mode;
	logic [1:0]  addr;
	logic [7:0]  wdata, rdata, conversion_data;
	logic        converter_power, converting, analog_output_pin_oe, factory_test_enable;
	logic [31:0] seed;
	int          fail_count, tests_run, ctl, dat, i, run;
	dac_register_control uut (
		.clk                 (clk),
		.sys_rst             (sys_rst),
		.addr                (addr),
		.wdata               (wdata),
		.wr_en               (wr_en),
		.rd_en               (rd_en),
		.special_mode        (special_mode),
		.wait_mode           (wait_mode),
		.stop_mode           (stop_mode),
		.rdata               (rdata),
		.conversion_data     (conversion_data),
		.converter_power     (converter_power),
		.converting          (converting),
		.analog_output_pin_oe(analog_output_pin_oe),
		.factory_test_enable (factory_test_enable)
	);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic check(input logic [7:0] got, input int exp);
		tests_run++;
		if (got !== 8'(exp)) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, 8'(exp));
		end
	endtask
	task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= w;
		rd_en <= !w;
		@(posedge clk);
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		#1;
	endtask
	task automatic reset_check;
		int k;
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		ctl = 0;
		dat = 0;
		for (k = 0; k < 4; k++) begin
			bus(1'b0, 2'(k), 8'h00);
			check(rdata, 0);
		end
		check(converter_power, 0);
		check(converting, 0);
		check(analog_output_pin_oe, 0);
		check(factory_test_enable, 0);
		check(conversion_data, 0);
		$display("reset test done");
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		fail_count++;
		final_report;
	end
	initial begin
		{wr_en, rd_en, special_mode, wait_mode, stop_mode} = '0;
		addr = 2'h0;
		wdata = 8'h00;
		seed = 32'hc316;
		{ctl, dat, fail_count, tests_run} = '0;
		reset_check;
		for (i = 0; i < 300; i++) begin
			seed = xs(seed);
			@(posedge clk);
			special_mode <= seed[8];
			wait_mode <= seed[9] & seed[10];
			stop_mode <= seed[11] & seed[12] & seed[13];
			bus(1'b1, seed[1:0], seed[23:16]);
			if (seed[1:0] == 2'h0)
				ctl = (seed[23:16] & 8'h8f) | ((special_mode ? seed[23:16] : ctl) & 8'h40);
			else if (seed[1] && seed[0] == ctl[3])
				dat = seed[23:16];
			@(posedge clk);
			#1;
			run = ctl[7] && !stop_mode && !(wait_mode && ctl[1]);
			check(converter_power, run);
			check(converting, run);
			check(analog_output_pin_oe, run && ctl[0]);
			check(factory_test_enable, ctl[6]);
			check(conversion_data, dat ^ (ctl[2] ? 8'h80 : 8'h00));
			bus(1'b0, seed[5:4], 8'h00);
			check(rdata, seed[5:4] == 2'h0 ? ctl : seed[5] && seed[4] == ctl[3] ? dat : 0);
		end
		$display("random test done");
		@(posedge clk);
		reset_check;
		final_report;
	end
endmodule
